// ### pkg/otsr_pkg.sv
package otsr_pkg;

    // Stage counts of the two variants
    localparam int STAGES_NARROW = 4;
    localparam int STAGES_WIDE   = 5;
    localparam int STAGES_MAX    = 5;

    // Width of the second parallel input set (narrow variant only)
    localparam int PAR_B_WIDTH   = 4;

    // Stage values
    localparam logic STAGE_CLEAR = 1'h0;
    localparam logic STAGE_SET   = 1'h1;

    // Position of the first stage in the chain
    localparam int FIRST_STAGE   = 0;

    // Vector of all cleared stages
    localparam logic [STAGES_MAX-1:0] ALL_CLEAR = 5'h0_0;

endpackage : otsr_pkg

// ### core/otsr_stage.sv
`timescale 1ns/1ps

module otsr_stage
(
    input  wire logic clk_in,
    input  wire logic rst_b_in,
    input  wire logic set_in,
    input  wire logic d_in,
    output logic      q_out
);

    logic stage_q;

    // Reset is tested first so it overrides a pending set
    always_ff @(posedge clk_in or negedge rst_b_in or posedge set_in)
    begin
        if (!rst_b_in)
        begin
            stage_q <= otsr_pkg::STAGE_CLEAR;
        end
        else if (set_in)
        begin
            stage_q <= otsr_pkg::STAGE_SET;
        end
        else
        begin
            stage_q <= d_in;
        end
    end

    assign q_out = stage_q;

endmodule : otsr_stage

// ### core/otsr_core.sv
// Contract
// - Shifts one stage per clock; four or five stages per variant.
// - Shift on rising clock edge; first stage takes the serial input.
// - Reset clears every stage at once, without a clock edge.
// - While loading, a one sets its stage; a zero never clears it.
// - Ones entry acts asynchronously, caught at once without the clock.
// - Four-stage variant has two load controls, each with four inputs.
// - Four-stage variant exposes only its final stage.
// - Five-stage variant exposes every stage.
// - Shift outputs change only on clock edge, from prior inputs.
`timescale 1ns/1ps

module otsr_core
#(
    parameter int STAGES = otsr_pkg::STAGES_NARROW
)
(
    input  wire logic                                 clk_in,
    input  wire logic                                 rst_b_in,
    input  wire logic                                 serial_in,
    input  wire logic                                 load_a_in,
    input  wire logic [otsr_pkg::STAGES_MAX-1:0]      par_a_in,
    input  wire logic                                 load_b_in,
    input  wire logic [otsr_pkg::PAR_B_WIDTH-1:0]     par_b_in,
    output logic                                      last_out,
    output logic      [otsr_pkg::STAGES_MAX-1:0]      stages_out
);

    // Second load source exists only on the narrow variant
    localparam logic HAS_SOURCE_B =
        (STAGES == otsr_pkg::STAGES_NARROW);

    // All stages are visible only on the wide variant
    localparam logic SHOWS_ALL =
        (STAGES == otsr_pkg::STAGES_WIDE);

    logic [otsr_pkg::STAGES_MAX-1:0] stage_q;
    logic [otsr_pkg::STAGES_MAX-1:0] stage_d;
    logic [otsr_pkg::STAGES_MAX-1:0] set_a;
    logic [otsr_pkg::STAGES_MAX-1:0] set_b;
    logic [otsr_pkg::STAGES_MAX-1:0] set_all;
    logic [otsr_pkg::STAGES_MAX-1:0] used_mask;
    logic [otsr_pkg::STAGES_MAX-1:0] par_b_wide;

    // Mask of the stages that this variant really builds
    function automatic logic [otsr_pkg::STAGES_MAX-1:0] stage_mask
    (
        input int count
    );
        logic [otsr_pkg::STAGES_MAX-1:0] m;
        m = otsr_pkg::ALL_CLEAR;
        for (int k = 0; k < otsr_pkg::STAGES_MAX; k++)
        begin
            if (k < count)
            begin
                m[k] = otsr_pkg::STAGE_SET;
            end
        end
        return m;
    endfunction : stage_mask

    // Ones-only entry: a load control passes ones, never zeros
    function automatic logic [otsr_pkg::STAGES_MAX-1:0] ones_entry
    (
        input logic                             load,
        input logic [otsr_pkg::STAGES_MAX-1:0]  par
    );
        logic [otsr_pkg::STAGES_MAX-1:0] s;
        s = otsr_pkg::ALL_CLEAR;
        for (int k = 0; k < otsr_pkg::STAGES_MAX; k++)
        begin
            s[k] = load & par[k];
        end
        return s;
    endfunction : ones_entry

    // Next shift value: serial into first stage, each stage moves up one
    function automatic logic [otsr_pkg::STAGES_MAX-1:0] shift_next
    (
        input logic [otsr_pkg::STAGES_MAX-1:0]  cur,
        input logic                             ser
    );
        logic [otsr_pkg::STAGES_MAX-1:0] n;
        n = otsr_pkg::ALL_CLEAR;
        n[otsr_pkg::FIRST_STAGE] = ser;
        for (int k = 1; k < otsr_pkg::STAGES_MAX; k++)
        begin
            n[k] = cur[k-1];
        end
        return n;
    endfunction : shift_next

    assign used_mask = stage_mask(STAGES);

    // Second source is narrower; upper stages get no set from it
    function automatic logic [otsr_pkg::STAGES_MAX-1:0] pad_source_b
    (
        input logic [otsr_pkg::PAR_B_WIDTH-1:0] p
    );
        logic [otsr_pkg::STAGES_MAX-1:0] w;
        w = {{(otsr_pkg::STAGES_MAX - otsr_pkg::PAR_B_WIDTH)
            {otsr_pkg::STAGE_CLEAR}}, p};
        return w;
    endfunction : pad_source_b

    // Reset blocks set so a held load cannot fight it
    function automatic logic [otsr_pkg::STAGES_MAX-1:0] gate_reset
    (
        input logic                             rst_b,
        input logic [otsr_pkg::STAGES_MAX-1:0]  set_raw
    );
        logic [otsr_pkg::STAGES_MAX-1:0] gated;
        gated = otsr_pkg::ALL_CLEAR;
        if (rst_b)
        begin
            gated = set_raw;
        end
        return gated;
    endfunction : gate_reset

    assign par_b_wide = pad_source_b(par_b_in);

    // Source A exists on both variants
    always_comb
    begin
        set_a = ones_entry(load_a_in, par_a_in);
    end

    // Source B only on the narrow variant, for merging two senders
    always_comb
    begin
        set_b = otsr_pkg::ALL_CLEAR;
        if (HAS_SOURCE_B)
        begin
            set_b = ones_entry(load_b_in, par_b_wide);
        end
    end

    // Set terms sit in the flop's event list, so a glitch here sets a stage;
    // loads must therefore settle before they are raised
    always_comb
    begin
        set_all = gate_reset(rst_b_in,
            (set_a | set_b) & used_mask);
    end

    // Shift path is purely edge driven, so feedback to serial is race free
    always_comb
    begin
        stage_d = shift_next(stage_q, serial_in) & used_mask;
    end

    // Unbuilt stages tie low and are never visible
    genvar g;
    generate
        for (g = 0; g < otsr_pkg::STAGES_MAX; g++)
        begin : g_stage
            if (g < STAGES)
            begin : g_built
                otsr_stage u_stage
                (
                    .clk_in   (clk_in),
                    .rst_b_in (rst_b_in),
                    .set_in   (set_all[g]),
                    .d_in     (stage_d[g]),
                    .q_out    (stage_q[g])
                );
            end
            else
            begin : g_absent
                assign stage_q[g] = otsr_pkg::STAGE_CLEAR;
            end
        end
    endgenerate

    // Last stage of the built chain; unbuilt stages never reach the pin
    function automatic logic last_pick
    (
        input logic [otsr_pkg::STAGES_MAX-1:0]  cur,
        input int                               count
    );
        logic r;
        r = otsr_pkg::STAGE_CLEAR;
        for (int k = 0; k < otsr_pkg::STAGES_MAX; k++)
        begin
            if (k == count - 1)
            begin
                r = cur[k];
            end
        end
        return r;
    endfunction : last_pick

    // Inner stages shown only on the wide variant
    function automatic logic [otsr_pkg::STAGES_MAX-1:0] show_stages
    (
        input logic [otsr_pkg::STAGES_MAX-1:0]  cur,
        input logic                             visible
    );
        logic [otsr_pkg::STAGES_MAX-1:0] v;
        v = otsr_pkg::ALL_CLEAR;
        if (visible)
        begin
            v = cur;
        end
        return v;
    endfunction : show_stages

    // Final stage is always brought out
    assign last_out = last_pick(stage_q, STAGES);

    always_comb
    begin
        stages_out = show_stages(stage_q, SHOWS_ALL);
    end

endmodule : otsr_core

// ### tb/otsr_props.sv
`timescale 1ns/1ps
module otsr_props #(parameter int STAGES = 5)
(
    input wire logic       clk_in,
    input wire logic       rst_b_in,
    input wire logic       serial_in,
    input wire logic       load_a_in,
    input wire logic [4:0] par_a_in,
    input wire logic       load_b_in,
    input wire logic [3:0] par_b_in,
    input wire logic       last_out,
    input wire logic [4:0] stages_out
);
    default clocking @(posedge clk_in);
    endclocking
    default disable iff (!rst_b_in);
    sequence s_calm;
        (rst_b_in && !load_a_in && !load_b_in) [*2];
    endsequence
    sequence s_run;
        (rst_b_in && !load_a_in && !load_b_in) [*6];
    endsequence
    a_first_stage:
        assert property ((STAGES == 5) && s_calm |->
            stages_out[0] == $past(serial_in))
        else $error("first stage wrong");
    a_stage_move:
        assert property ((STAGES == 5) && s_calm |->
            stages_out[4:1] == $past(stages_out[3:0]))
        else $error("shift wrong");
    a_pipe_depth:
        assert property (s_run |-> last_out == $past(serial_in, STAGES))
        else $error("depth wrong");
    a_load_sets:
        assert property ((STAGES == 5) && load_a_in |->
            (stages_out & par_a_in) == par_a_in)
        else $error("set missed");
    a_load_b_sets:
        assert property ((STAGES == 4) && load_b_in && par_b_in[3] |->
            last_out)
        else $error("second source missed");
    a_zero_keeps:
        assert property ((STAGES == 5) && load_a_in && $past(load_a_in)
            && $past(rst_b_in)
            && $stable(par_a_in) |-> stages_out ==
            ({$past(stages_out[3:0]), $past(serial_in)} | par_a_in))
        else $error("zero cleared");
    a_reset_zero:
        assert property (disable iff (1'b0)
            !rst_b_in |-> stages_out == 5'h0_0 && !last_out)
        else $error("reset lost");
    a_release_zero:
        assert property ($rose(rst_b_in) && !load_a_in |-> !stages_out)
        else $error("not clear");
    a_last_stage:
        assert property ((STAGES == 5) ? last_out == stages_out[STAGES-1]
            : stages_out == 5'h0_0)
        else $error("last wrong");
endmodule : otsr_props

// ### tb/otsr_feed.sv
`timescale 1ns/1ps
module otsr_feed
(
    input  wire logic       clk_in,
    input  wire logic [4:0] bits_in,
    output logic            serial_out
);
    logic [2:0] idx_q = 3'h0;
    // Moves before the bench does, so the level is settled when sampled
    always @(posedge clk_in)
        idx_q <= #1 (idx_q == 3'h4) ? 3'h0 : idx_q + 3'h1;
    assign serial_out = bits_in[idx_q];
endmodule : otsr_feed

// ### tb/testbench.sv
`timescale 1ns/1ps
module testbench;
    logic       clk, rst_b, la, lb, last, last_n, ser;
    logic [4:0] pa, st, st_n, bits, mdl;
    logic [3:0] pb, mdl_n;
    int         bad_count, total_checks;
    otsr_core #(.STAGES(5)) dut (.clk_in(clk), .rst_b_in(rst_b),
        .serial_in(ser), .load_a_in(la), .par_a_in(pa), .load_b_in(lb),
        .par_b_in(pb), .last_out(last), .stages_out(st));
    otsr_core #(.STAGES(4)) dut_n (.clk_in(clk), .rst_b_in(rst_b),
        .serial_in(ser), .load_a_in(la), .par_a_in(pa), .load_b_in(lb),
        .par_b_in(pb), .last_out(last_n), .stages_out(st_n));
    otsr_feed feed (.clk_in(clk), .bits_in(bits), .serial_out(ser));
    task automatic chk(string nm, logic [4:0] seen, logic [4:0] want);
        total_checks++;
        if (seen !== want)
        begin
            bad_count++;
            $display("mismatch %s expected %h seen %h", nm, want, seen);
        end
    endtask : chk
    task automatic wrap_up;
        if (bad_count == 0 && total_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : wrap_up
    task automatic tick;
        mdl = {mdl[3:0], ser} | (la ? pa : 5'h0_0);
        mdl_n = {mdl_n[2:0], ser} | (la ? pa[3:0] : 4'h0)
            | (lb ? pb : 4'h0);
        @(posedge clk);
        #2;
        chk("stages", st, mdl);
        chk("last", {4'h0, last}, {4'h0, mdl[4]});
        chk("narrow last", {4'h0, last_n}, {4'h0, mdl_n[3]});
        chk("narrow hidden", st_n, 5'h0_0);
    endtask : tick
    task automatic t_shift;
        bits = 5'h0_d;
        repeat (12) tick();
    endtask : t_shift
    task automatic t_load;
        bits = 5'h0_0;
        repeat (5) tick();
        la = 1'h1;
        pa = 5'h0_a;
        mdl = mdl | pa;
        mdl_n = mdl_n | pa[3:0];
        #5;
        chk("async set", st, mdl);
        chk("narrow set", {4'h0, last_n}, {4'h0, mdl_n[3]});
        repeat (2) tick();
        pa = 5'h1_1;
        mdl = mdl | pa;
        mdl_n = mdl_n | pa[3:0];
        repeat (2) tick();
        la = 1'h0;
        repeat (3) tick();
    endtask : t_load
    task automatic t_merge;
        bits = 5'h0_0;
        repeat (5) tick();
        {la, pa, lb, pb} = {1'h1, 5'h0_1, 1'h1, 4'h8};
        mdl = mdl | pa;
        mdl_n = mdl_n | pa[3:0] | pb;
        #5;
        chk("merge last", {4'h0, last_n}, 5'h0_1);
        tick();
        {la, lb} = 2'h0;
        repeat (4) tick();
    endtask : t_merge
    task automatic t_reset;
        la = 1'h1;
        pa = 5'h1_f;
        #10;
        rst_b = 1'h0;
        #5;
        chk("reset", st, 5'h0_0);
        chk("narrow reset", {4'h0, last_n}, 5'h0_0);
        la = 1'h0;
        mdl = 5'h0_0;
        mdl_n = 4'h0;
        @(posedge clk);
        #2;
        rst_b = 1'h1;
        repeat (2) tick();
    endtask : t_reset
    initial
    begin
        clk = 1'h0;
        forever #20 clk = ~clk;
    end
    initial
    begin
        #10000;
        bad_count++;
        wrap_up();
    end
    initial
    begin
        {rst_b, la, lb, pa, pb, bits, mdl, mdl_n} =
            {3'h3, 5'h1_f, 4'hf, 14'h0};
        repeat (4) @(posedge clk);
        #2;
        chk("held", st, 5'h0_0);
        chk("held narrow", {4'h0, last_n}, 5'h0_0);
        {la, lb, pa, pb} = 11'h000;
        rst_b = 1'h1;
        t_shift();
        t_load();
        t_merge();
        t_reset();
        wrap_up();
    end
endmodule : testbench
bind otsr_core otsr_props #(.STAGES(STAGES)) props (.clk_in(clk_in),
    .rst_b_in(rst_b_in), .serial_in(serial_in), .load_a_in(load_a_in),
    .par_a_in(par_a_in), .load_b_in(load_b_in), .par_b_in(par_b_in),
    .last_out(last_out), .stages_out(stages_out));
